// ===== core/nmpf_pkg.sv
// Package of the node mode power sequencer: modes, flag layouts, register map, timing
// Assumes a single system clock of 100 MHz and classic Wishbone register access
package nmpf_pkg;

    // ************************************************
    // Operating modes
    // ************************************************
    typedef enum logic [2:0] {
        MODE_NORMAL,
        MODE_RXONLY,
        MODE_GOSLEEP,
        MODE_STANDBY,
        MODE_SLEEP
    } nmpf_mode_type;

    // ************************************************
    // Flag carriers
    // ************************************************
    typedef struct packed {
        logic coreSupplyLowFlag;
        logic batterySupplyLowFlag;
        logic ioSupplyLowFlag;
    } nmpf_uv_type;

    typedef struct packed {
        logic modeChange;
        logic uvRecover;
        logic uvDetect;
        logic wakeSet;
    } nmpf_irq_type;

    // ************************************************
    // Register map
    // ************************************************
    localparam logic [3:0] REG_STATUS = 4'h0;
    localparam logic [3:0] REG_CTRL = 4'h4;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h8;
    localparam logic [3:0] REG_IRQ_MASK = 4'hc;
    localparam logic [1:0] CTRL_RESET = 2'h3;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;
    localparam int CTRL_BUS_WAKE_BIT = 0;
    localparam int CTRL_LOCAL_WAKE_BIT = 1;

    // ************************************************
    // Timing
    // ************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int GTS_HOLD_NS = 20000;
    localparam int GTS_HOLD_CYCLES = (GTS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ===== core/node_mode_power_fsm.sv
// Node mode power sequencer: mode pins, wake events, undervoltage flags, Wishbone registers
// Assumes mode pins from the host, synchronous wake and undervoltage detector levels
`timescale 1ns/1ps
module node_mode_power_fsm
    import nmpf_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = GTS_HOLD_CYCLES
)(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic wbCyc,
    input wire logic wbStb,
    input wire logic wbWe,
    input wire logic [3:0] wbAdr,
    input wire logic [3:0] wbSel,
    input wire logic [31:0] wbDatW,
    output logic [31:0] wbDatR,
    output logic wbAck,
    output logic irq,
    input wire logic standbySelectN,
    input wire logic modeEnable,
    input wire logic busWake,
    input wire logic localWake,
    input wire logic ioLowDet,
    input wire logic batteryLowDet,
    input wire logic coreLowDet,
    input wire logic busActivityIn,
    input wire logic rxBitIn,
    output logic busActivityOut,
    output logic rxBitOut,
    output logic supplySwitchOneOut,
    output logic supplySwitchOneOe,
    output logic supplySwitchTwoOut,
    output logic supplySwitchTwoOe,
    output nmpf_mode_type modeOut
);

    localparam int HW = $clog2(HOLD_CYCLES + 1);

    generate
        if (HOLD_CYCLES < 1)
        begin : g_bad_hold
            $error("HOLD_CYCLES must be at least 1");
        end
    endgenerate

    // ************************************************
    // Functions
    // ************************************************
    function automatic nmpf_mode_type selMode(input logic selPin, input logic enPin);
        nmpf_mode_type m;
        m = MODE_STANDBY;
        case ({selPin, enPin})
            2'h3: m = MODE_NORMAL;
            2'h2: m = MODE_RXONLY;
            2'h1: m = MODE_GOSLEEP;
            default: m = MODE_STANDBY;
        endcase
        return m;
    endfunction

    function automatic logic lowPower(input nmpf_mode_type m);
        return (m == MODE_STANDBY) || (m == MODE_GOSLEEP) || (m == MODE_SLEEP);
    endfunction

    // ************************************************
    // Declarations
    // ************************************************
    logic selPinS1_q, selPinS2_q, selPinS3_q;
    logic enS1_q, enS2_q;
    logic ioPrev_q, batPrev_q, corePrev_q;
    nmpf_mode_type state_q, state_d, sel;
    logic wake_q, wake_d;
    logic viaStandby_q, viaStandby_d;
    nmpf_uv_type uv_q, uv_d;
    logic [HW-1:0] holdCnt_q;
    logic holdDone;
    logic selPinRise, wakeEvt, ioRise, batRise, coreRise, ioFall, batFall, coreFall;
    logic [1:0] ctrl_q;
    nmpf_irq_type irqStat_q, irqMask_q, irqEvt;
    logic wbReq, wbWr;

    // ************************************************
    // Pin synchronisers and edges
    // ************************************************
    // two stage sync, edge from stage two
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            selPinS1_q <= 1'b0;
            selPinS2_q <= 1'b0;
            selPinS3_q <= 1'b0;
            enS1_q <= 1'b0;
            enS2_q <= 1'b0;
        end
        else
        begin
            selPinS1_q <= standbySelectN;
            selPinS2_q <= selPinS1_q;
            selPinS3_q <= selPinS2_q;
            enS1_q <= modeEnable;
            enS2_q <= enS1_q;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ioPrev_q <= 1'b0;
            batPrev_q <= 1'b0;
            corePrev_q <= 1'b0;
        end
        else
        begin
            ioPrev_q <= ioLowDet;
            batPrev_q <= batteryLowDet;
            corePrev_q <= coreLowDet;
        end
    end

    assign selPinRise = selPinS2_q & ~selPinS3_q;
    assign sel = selMode(selPinS2_q, enS2_q);
    assign ioRise = ioLowDet & ~ioPrev_q;
    assign batRise = batteryLowDet & ~batPrev_q;
    assign coreRise = coreLowDet & ~corePrev_q;
    assign ioFall = ~ioLowDet & ioPrev_q & uv_q.ioSupplyLowFlag;
    assign batFall = ~batteryLowDet & batPrev_q & uv_q.batterySupplyLowFlag;
    assign coreFall = ~coreLowDet & corePrev_q & uv_q.coreSupplyLowFlag;
    assign wakeEvt = selPinRise | (busWake & ctrl_q[CTRL_BUS_WAKE_BIT])
        | (localWake & ctrl_q[CTRL_LOCAL_WAKE_BIT]);

    // ************************************************
    // Go-to-sleep hold timer
    // ************************************************
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            holdCnt_q <= '0;
        end
        else if (state_q != MODE_GOSLEEP)
        begin
            holdCnt_q <= '0;
        end
        else if (!holdDone)
        begin
            holdCnt_q <= holdCnt_q + HW'(1);
        end
    end

    assign holdDone = (holdCnt_q == HW'(HOLD_CYCLES));

    // ************************************************
    // Mode transitions
    // ************************************************
    always_comb
    begin
        state_d = state_q;
        wake_d = wake_q;
        viaStandby_d = 1'b0;
        uv_d = uv_q;
        if (ioRise)
            uv_d.ioSupplyLowFlag = 1'b1;
        if (batRise)
            uv_d.batterySupplyLowFlag = 1'b1;
        if (coreRise)
            uv_d.coreSupplyLowFlag = 1'b1;
        if (ioFall)
            uv_d.ioSupplyLowFlag = 1'b0;
        if (batFall)
            uv_d.batterySupplyLowFlag = 1'b0;
        if (coreFall)
            uv_d.coreSupplyLowFlag = 1'b0;
        if (ioRise || batRise || coreRise)
        begin
            // undervoltage entry, IO and battery first
            wake_d = 1'b0;
            if (ioRise || batRise)
                state_d = MODE_SLEEP;
            else if (state_q == MODE_NORMAL || state_q == MODE_RXONLY)
                state_d = MODE_STANDBY;
        end
        else if (viaStandby_q)
        begin
            state_d = sel;
        end
        else if (wakeEvt && lowPower(state_q))
        begin
            wake_d = 1'b1;
            uv_d = '0;
            if (state_q == MODE_SLEEP && sel != MODE_STANDBY)
            begin
                state_d = MODE_STANDBY;
                viaStandby_d = 1'b1;
            end
            else
            begin
                state_d = sel;
            end
        end
        else if (state_q == MODE_STANDBY && (ioFall || batFall || coreFall))
        begin
            if (ioFall && !selPinS2_q)
            begin
                state_d = MODE_SLEEP;
                wake_d = 1'b0;
            end
            else
            begin
                state_d = sel;
            end
            if (batFall && !(ioFall && !selPinS2_q))
            begin
                wake_d = 1'b1;
                uv_d = '0;
            end
        end
        else if (uv_q == '0)
        begin
            case (state_q)
                MODE_NORMAL, MODE_RXONLY, MODE_STANDBY:
                    state_d = sel;
                MODE_GOSLEEP:
                begin
                    // auto Sleep only with wake clear
                    if (!holdDone)
                        state_d = sel;
                    else if (!wake_q)
                        state_d = MODE_SLEEP;
                end
                default:
                    state_d = state_q;
            endcase
        end
        if (state_d == MODE_NORMAL)
            wake_d = 1'b0;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_q <= MODE_STANDBY;
            wake_q <= 1'b0;
            viaStandby_q <= 1'b0;
            uv_q <= '0;
        end
        else
        begin
            state_q <= state_d;
            wake_q <= wake_d;
            viaStandby_q <= viaStandby_d;
            uv_q <= uv_d;
        end
    end

    // ************************************************
    // Pin outputs
    // ************************************************
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            busActivityOut <= 1'b1;
            rxBitOut <= 1'b1;
            supplySwitchOneOut <= 1'b1;
            supplySwitchOneOe <= 1'b1;
            supplySwitchTwoOut <= 1'b0;
            supplySwitchTwoOe <= 1'b0;
            modeOut <= MODE_STANDBY;
        end
        else
        begin
            modeOut <= state_d;
            supplySwitchOneOut <= (state_d != MODE_SLEEP);
            supplySwitchOneOe <= (state_d != MODE_SLEEP);
            if (lowPower(state_d))
            begin
                busActivityOut <= ~wake_d;
                rxBitOut <= ~wake_d;
                supplySwitchTwoOut <= wake_d;
                supplySwitchTwoOe <= wake_d;
            end
            else
            begin
                busActivityOut <= busActivityIn;
                rxBitOut <= rxBitIn;
                supplySwitchTwoOut <= 1'b1;
                supplySwitchTwoOe <= 1'b1;
            end
        end
    end

    // ************************************************
    // Wishbone slave
    // ************************************************
    assign wbReq = wbCyc & wbStb & ~wbAck;
    assign wbWr = wbReq & wbWe & wbSel[0];

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            wbAck <= 1'b0;
            wbDatR <= 32'h0;
        end
        else
        begin
            wbAck <= wbReq;
            wbDatR <= 32'h0;
            if (wbReq && !wbWe)
            begin
                case (wbAdr)
                    REG_STATUS: wbDatR <= {25'h0, uv_q, wake_q, state_q};
                    REG_CTRL: wbDatR <= {30'h0, ctrl_q};
                    REG_IRQ_STATUS: wbDatR <= {28'h0, irqStat_q};
                    REG_IRQ_MASK: wbDatR <= {28'h0, irqMask_q};
                    default: wbDatR <= 32'h0;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ctrl_q <= CTRL_RESET;
            irqMask_q <= IRQ_MASK_RESET;
        end
        else if (wbWr)
        begin
            if (wbAdr == REG_CTRL)
                ctrl_q <= wbDatW[1:0];
            if (wbAdr == REG_IRQ_MASK)
                irqMask_q <= wbDatW[3:0];
        end
    end

    // ************************************************
    // Interrupts
    // ************************************************
    assign irqEvt.wakeSet = wake_d & ~wake_q;
    assign irqEvt.uvDetect = ioRise | batRise | coreRise;
    assign irqEvt.uvRecover = ioFall | batFall | coreFall;
    assign irqEvt.modeChange = (state_d != state_q);

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            irqStat_q <= '0;
        end
        else if (wbWr && wbAdr == REG_IRQ_STATUS)
        begin
            irqStat_q <= (irqStat_q & ~wbDatW[3:0]) | irqEvt;
        end
        else
        begin
            irqStat_q <= irqStat_q | irqEvt;
        end
    end

    assign irq = |(irqStat_q & irqMask_q);

    // ************************************************
    // Assertions
    // ************************************************
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    sequence s_sleep_exit;
        (state_q == MODE_SLEEP) ##1 (state_q != MODE_SLEEP);
    endsequence

    sequence s_hold_expired;
        (state_q == MODE_GOSLEEP) && holdDone && !wake_q && uv_q == '0
            && !wakeEvt && !ioRise && !batRise && !coreRise;
    endsequence

    a_normal_wake_low: assert property (state_q == MODE_NORMAL |-> !wake_q)
        else $error("Wake flag set in Normal");

    a_uv_to_sleep: assert property ((ioRise || batRise) |=> state_q == MODE_SLEEP && !wake_q)
        else $error("Supply undervoltage did not force Sleep");

    a_core_to_standby: assert property (coreRise && !ioRise && !batRise
        && (state_q == MODE_NORMAL || state_q == MODE_RXONLY) |=> state_q == MODE_STANDBY)
        else $error("Core undervoltage did not force Standby");

    a_wake_clears_uv: assert property ($rose(wake_q) |-> uv_q == '0)
        else $error("Undervoltage flag left set by wake");

    a_select_sets_wake: assert property (selPinRise && lowPower(state_q) && !viaStandby_q
        && !ioRise && !batRise && !coreRise |=> wake_q || state_q == MODE_NORMAL)
        else $error("Select edge did not set wake");

    a_sleep_via_standby: assert property (s_sleep_exit |-> state_q == MODE_STANDBY
        ##1 (state_q == $past(sel) || $past(ioRise) || $past(batRise) || $past(coreRise)))
        else $error("Sleep exit skipped Standby");

    a_hold_to_sleep: assert property (s_hold_expired |=> state_q == MODE_SLEEP)
        else $error("Go-to-sleep hold did not enter Sleep");

    a_hold_time: assert property ($rose(state_q == MODE_GOSLEEP) |-> !holdDone)
        else $error("Hold timer not restarted");

    a_standby_pins: assert property (state_q == MODE_STANDBY && wake_q
        |-> supplySwitchTwoOe && supplySwitchTwoOut && !busActivityOut && !rxBitOut)
        else $error("Standby outputs wrong with wake set");

    a_pin_follow: assert property (state_q == MODE_STANDBY && uv_q == '0 && !wakeEvt && !viaStandby_q
        && !ioRise && !batRise && !coreRise |=> state_q == $past(sel))
        else $error("Standby did not follow pins");

    a_io_recovery: assert property (state_q == MODE_STANDBY && ioFall && !selPinS2_q && !wakeEvt
        && !viaStandby_q && !ioRise && !batRise && !coreRise |=> state_q == MODE_SLEEP && !wake_q)
        else $error("IO recovery did not enter Sleep");

    a_bat_recovery: assert property (state_q == MODE_STANDBY && batFall && !ioFall && sel != MODE_NORMAL
        && !wakeEvt && !viaStandby_q && !ioRise && !batRise && !coreRise |=> wake_q)
        else $error("Battery recovery did not set wake");

endmodule

// ===== verif/nmpf_host_model.sv
// Host side model: drives the standby select pin and the second mode pin
// Assumes the 100 MHz system clock; the bench calls setPins for each change
`timescale 1ns/1ps
module nmpf_host_model
#(
    parameter int DETECT_CYCLES = 4
)(
    input wire logic clk_sys,
    output logic standbySelectN,
    output logic modeEnable
);
    initial
    begin
        standbySelectN = 1'b0;
        modeEnable = 1'b0;
    end

    task automatic setPins(input logic sel, input logic en);
        @(posedge clk_sys);
        modeEnable <= en;
        if (!sel && standbySelectN && !en)
        begin
            repeat (DETECT_CYCLES) @(posedge clk_sys);
        end
        standbySelectN <= sel;
    endtask
endmodule

// ===== verif/test_node_mode_power_fsm.sv
// Self-checking bench of the node mode power sequencer
// Assumes the host model for the mode pins and a Wishbone master in this module
`timescale 1ns/1ps
module test_node_mode_power_fsm
    import nmpf_pkg::*;
;
    localparam int HOLD = 12;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic wbCyc = 1'b0;
    logic wbStb = 1'b0;
    logic wbWe = 1'b0;
    logic [3:0] wbAdr = 4'h0;
    logic [3:0] wbSel = 4'h0;
    logic [31:0] wbDatW = 32'h0;
    logic busWake = 1'b0;
    logic localWake = 1'b0;
    logic ioLowDet = 1'b0;
    logic batteryLowDet = 1'b0;
    logic coreLowDet = 1'b0;
    logic busActivityIn = 1'b1;
    logic rxBitIn = 1'b1;
    logic [31:0] wbDatR;
    logic wbAck;
    logic irq;
    logic busActivityOut;
    logic rxBitOut;
    logic sw1Out;
    logic sw1Oe;
    logic sw2Out;
    logic sw2Oe;
    logic standbySelectN;
    logic modeEnable;
    nmpf_mode_type modeOut;
    int numErrors = 0;
    int nChecks = 0;
    logic [31:0] rd;

    always #5 clk_sys = ~clk_sys;

    nmpf_host_model nmpf_host_model_inst (.clk_sys(clk_sys), .standbySelectN(standbySelectN),
        .modeEnable(modeEnable));

    node_mode_power_fsm #(.HOLD_CYCLES(HOLD)) node_mode_power_fsm_inst (.clk_sys(clk_sys), .rst(rst),
        .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW),
        .wbDatR(wbDatR), .wbAck(wbAck), .irq(irq), .standbySelectN(standbySelectN),
        .modeEnable(modeEnable), .busWake(busWake), .localWake(localWake), .ioLowDet(ioLowDet),
        .batteryLowDet(batteryLowDet), .coreLowDet(coreLowDet), .busActivityIn(busActivityIn),
        .rxBitIn(rxBitIn), .busActivityOut(busActivityOut), .rxBitOut(rxBitOut),
        .supplySwitchOneOut(sw1Out), .supplySwitchOneOe(sw1Oe), .supplySwitchTwoOut(sw2Out),
        .supplySwitchTwoOe(sw2Oe), .modeOut(modeOut));

    // ************************************************
    // Shared tasks
    // ************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp)
        begin
            numErrors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wbXfer(input logic we, input logic [3:0] adr, input logic [31:0] dat,
        input logic [3:0] sel);
        int n;
        n = 0;
        @(posedge clk_sys);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatW <= dat;
        wbSel <= sel;
        do
        begin
            @(posedge clk_sys);
            n++;
        end
        while (wbAck !== 1'b1 && n < 20);
        rd = wbDatR;
        chk(32'(n < 20), 32'h1);
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
    endtask

    task automatic rdChk(input logic [3:0] adr, input logic [31:0] exp);
        wbXfer(1'b0, adr, 32'h0, 4'hf);
        chk(rd, exp);
    endtask

    task automatic expMode(input nmpf_mode_type m);
        int n;
        n = 0;
        while (modeOut !== m && n < 30)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk(modeOut, m);
    endtask

    // ************************************************
    // Scenarios
    // ************************************************
    task automatic tReset;
        @(posedge clk_sys);
        chk(modeOut, MODE_STANDBY);
        chk({sw2Out, sw2Oe, busActivityOut, rxBitOut, sw1Out, sw1Oe}, 6'hf);
        rdChk(REG_STATUS, 32'h3);
        rdChk(REG_CTRL, 32'h3);
        rdChk(REG_IRQ_MASK, 32'h0);
        rdChk(4'h2, 32'h0);
    endtask

    task automatic tPins;
        nmpf_host_model_inst.setPins(1'b1, 1'b1);
        expMode(MODE_NORMAL);
        rdChk(REG_STATUS, 32'h0);
        @(posedge clk_sys);
        busActivityIn <= 1'b0;
        rxBitIn <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk({busActivityOut, rxBitOut, sw2Out, sw2Oe}, 4'h3);
        busActivityIn <= 1'b1;
        rxBitIn <= 1'b1;
        nmpf_host_model_inst.setPins(1'b1, 1'b0);
        expMode(MODE_RXONLY);
        nmpf_host_model_inst.setPins(1'b0, 1'b1);
        expMode(MODE_GOSLEEP);
        nmpf_host_model_inst.setPins(1'b0, 1'b0);
        expMode(MODE_STANDBY);
        nmpf_host_model_inst.setPins(1'b1, 1'b0);
        expMode(MODE_RXONLY);
        rdChk(REG_STATUS, 32'h9);
    endtask

    task automatic tSleep;
        nmpf_host_model_inst.setPins(1'b1, 1'b1);
        expMode(MODE_NORMAL);
        nmpf_host_model_inst.setPins(1'b0, 1'b1);
        expMode(MODE_GOSLEEP);
        repeat (HOLD - 3) @(posedge clk_sys);
        chk(modeOut, MODE_GOSLEEP);
        expMode(MODE_SLEEP);
        chk({sw1Out, sw1Oe, sw2Oe, busActivityOut, rxBitOut}, 5'h3);
        nmpf_host_model_inst.setPins(1'b0, 1'b0);
        repeat (6) @(posedge clk_sys);
        chk(modeOut, MODE_SLEEP);
        nmpf_host_model_inst.setPins(1'b0, 1'b1);
    endtask

    task automatic tWake;
        int n;
        wbXfer(1'b1, REG_CTRL, 32'h0, 4'h0);
        rdChk(REG_CTRL, 32'h3);
        wbXfer(1'b1, REG_CTRL, 32'h2, 4'hf);
        rdChk(REG_CTRL, 32'h2);
        @(posedge clk_sys);
        busWake <= 1'b1;
        @(posedge clk_sys);
        busWake <= 1'b0;
        repeat (6) @(posedge clk_sys);
        chk(modeOut, MODE_SLEEP);
        localWake <= 1'b1;
        @(posedge clk_sys);
        localWake <= 1'b0;
        n = 0;
        while (modeOut === MODE_SLEEP && n < 10)
        begin
            @(posedge clk_sys);
            n++;
        end
        chk(modeOut, MODE_STANDBY);
        @(posedge clk_sys);
        chk(modeOut, MODE_GOSLEEP);
        chk({sw2Out, sw2Oe, busActivityOut, rxBitOut}, 4'hc);
        rdChk(REG_STATUS, 32'ha);
        repeat (HOLD + 6) @(posedge clk_sys);
        chk(modeOut, MODE_GOSLEEP);
        wbXfer(1'b1, REG_CTRL, 32'h3, 4'hf);
    endtask

    task automatic tUv;
        nmpf_host_model_inst.setPins(1'b1, 1'b1);
        expMode(MODE_NORMAL);
        coreLowDet <= 1'b1;
        expMode(MODE_STANDBY);
        rdChk(REG_STATUS, 32'h43);
        nmpf_host_model_inst.setPins(1'b1, 1'b0);
        repeat (6) @(posedge clk_sys);
        chk(modeOut, MODE_STANDBY);
        coreLowDet <= 1'b0;
        expMode(MODE_RXONLY);
        batteryLowDet <= 1'b1;
        coreLowDet <= 1'b1;
        expMode(MODE_SLEEP);
        nmpf_host_model_inst.setPins(1'b0, 1'b0);
        nmpf_host_model_inst.setPins(1'b1, 1'b0);
        expMode(MODE_RXONLY);
        rdChk(REG_STATUS, 32'h9);
        batteryLowDet <= 1'b0;
        coreLowDet <= 1'b0;
        @(posedge clk_sys);
        ioLowDet <= 1'b1;
        expMode(MODE_SLEEP);
        rdChk(REG_STATUS, 32'h14);
        ioLowDet <= 1'b0;
    endtask

    task automatic tIrq;
        wbXfer(1'b1, REG_STATUS, 32'h0, 4'hf);
        rdChk(REG_STATUS, 32'h4);
        rdChk(REG_IRQ_STATUS, 32'hf);
        chk(irq, 1'b0);
        wbXfer(1'b1, REG_IRQ_MASK, 32'h2, 4'hf);
        chk(irq, 1'b1);
        wbXfer(1'b1, REG_IRQ_STATUS, 32'h2, 4'hf);
        chk(irq, 1'b0);
        rdChk(REG_IRQ_STATUS, 32'hd);
        wbXfer(1'b1, REG_IRQ_MASK, 32'hf, 4'hf);
        chk(irq, 1'b1);
        wbXfer(1'b1, REG_IRQ_STATUS, 32'hd, 4'hf);
        chk(irq, 1'b0);
        rdChk(REG_IRQ_MASK, 32'hf);
        busWake <= 1'b1;
        @(posedge clk_sys);
        busWake <= 1'b0;
        expMode(MODE_RXONLY);
        chk(irq, 1'b1);
        rdChk(REG_STATUS, 32'h9);
    endtask

    // ************************************************
    // Run control
    // ************************************************
    task automatic giveVerdict;
        $display("Checks %0d, errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        tReset();
        tPins();
        tSleep();
        tWake();
        tUv();
        tIrq();
        giveVerdict();
    end

    initial
    begin
        repeat (20000) @(posedge clk_sys);
        numErrors++;
        giveVerdict();
    end
endmodule
